// File: rtl/bsq_pkg.sv
// Constants, encodings and state codes of the post-reset boot sequencer.
// Assumes a single 10 MHz clock domain; all users import the whole package.
package bsq_pkg;
	localparam int DW = 16;
	localparam int AW = 24;
	localparam int FIFO_W = 16;
	localparam int FIFO_D = 16;
	localparam logic [23:0] DSP_INIT = 24'h000090;
	localparam logic [23:0] SSP_INIT = 24'h000080;
	localparam logic [23:0] ENTRY_HI_ADDR = 24'h000060;
	localparam logic [23:0] ENTRY_LO_ADDR = 24'h000061;
	localparam logic [23:0] DIRECT_ENTRY = 24'h400000;
	localparam logic [1:0] STK_32_SLOW = 2'h0;
	localparam logic [15:0] DELAY_TAG = 16'hFFFF;
	localparam logic [1:0] SETTLE_CYC = 2'h2;
	localparam logic [3:0] BM_SPI24 = 4'h1;
	localparam logic [3:0] BM_USB = 4'h2;
	localparam logic [3:0] BM_I2C = 4'h3;
	localparam logic [3:0] BM_HP_MUX = 4'h5;
	localparam logic [3:0] BM_HP_NMUX = 4'h6;
	localparam logic [3:0] BM_DIRECT = 4'h8;
	localparam logic [3:0] BM_SPI16 = 4'h9;
	localparam logic [3:0] BM_PAR8 = 4'hA;
	localparam logic [3:0] BM_PAR16 = 4'hB;
	localparam logic [3:0] BM_SER16 = 4'hE;
	localparam logic [3:0] BM_SER8 = 4'hF;
	localparam longint SINE_STEP = 64'd26353589;
	localparam int SINE_FRAC = 30;
	typedef enum logic [2:0] {
		SRC_NONE = 3'h0, SRC_HOST = 3'h1, SRC_PAR = 3'h2, SRC_SERIAL = 3'h3,
		SRC_SPI = 3'h4, SRC_USB = 3'h5, SRC_I2C = 3'h6
	} bsq_src_t;
	typedef enum logic [3:0] {
		ST_INIT = 4'h0, ST_SELECT = 4'h1, ST_HOST_WAIT = 4'h2,
		ST_ENT_HI = 4'h3, ST_ENT_LO = 4'h4, ST_REG_CNT = 4'h5,
		ST_REG_ADDR = 4'h6, ST_REG_VAL = 4'h7, ST_DELAY = 4'h8,
		ST_SEC_LEN = 4'h9, ST_SEC_DH = 4'hA, ST_SEC_DL = 4'hB,
		ST_SEC_DATA = 4'hC, ST_FINISH = 4'hD, ST_RUN = 4'hE, ST_ERR = 4'hF
	} bsq_state_t;
endpackage

// File: rtl/bsq_top.sv
// Boot sequencer: init of processor state, boot-table parsing, sine ROM.
// Assumes boot words arrive on mclk from the selected peripheral; pins async.

module bsq_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int PW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [PW:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic push, pop;
	assign in_ready = (wp_r - rp_r) != (PW+1)'(D);
	assign out_valid = wp_r != rp_r;
	assign out_data = mem[rp_r[PW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_comb begin
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end
	// Storage has no reset; only pointers define contents
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wp_r[PW-1:0]] <= in_data;
		end
	end
endmodule

module bsq_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] boot_select_pins,
	input wire logic host_load_done,
	input wire logic [23:0] host_entry,
	input wire logic [15:0] src_data,
	input wire logic src_valid,
	output logic src_ready,
	output bsq_pkg::bsq_src_t src_sel,
	output logic par_width16,
	output logic spi_addr24,
	output logic ser_width16,
	output logic [23:0] data_stack_pointer,
	output logic [23:0] system_stack_pointer,
	output logic [1:0] stack_mode,
	output logic global_interrupt_mask,
	output logic sign_extension_mode,
	output logic legacy_compatibility_mode,
	output logic mem_we,
	output logic [23:0] mem_addr,
	output logic [15:0] mem_wdata,
	output logic io_we,
	output logic [15:0] io_addr,
	output logic [15:0] io_wdata,
	output logic exec_start,
	output logic [23:0] exec_addr,
	output logic boot_done,
	output logic boot_error,
	output logic handshake_o,
	output logic handshake_oe,
	input wire logic [7:0] sine_addr,
	output logic [15:0] sine_data
);
	import bsq_pkg::*;

	// Minsky rotation: tiny elaboration cost, no table file needed
	function automatic logic [15:0] sine_fn(int idx);
		longint s;
		longint c;
		longint v;
		s = 0;
		c = 64'sd1 <<< SINE_FRAC;
		for (int k = 0; k < idx; k++) begin
			c = c - ((SINE_STEP * s) >>> SINE_FRAC);
			s = s + ((SINE_STEP * c) >>> SINE_FRAC);
		end
		v = s >>> 15;
		if (v > 32767) v = 32767;
		if (v < -32767) v = -32767;
		return v[15:0];
	endfunction

	logic [15:0] sine_rom [256];
	for (genvar i = 0; i < 256; i++) begin : g_sine
		assign sine_rom[i] = sine_fn(i);
	end

	logic [3:0] pins_m_r, pins_s_r;
	logic done_m_r, done_s_r;
	logic [23:0] hent_m_r, hent_s_r;
	bsq_state_t state_r, state_nxt;
	bsq_src_t src_r, src_nxt;
	logic [3:0] mode_r, mode_nxt;
	logic [1:0] settle_r, settle_nxt, stk_r, stk_nxt;
	logic [23:0] dsp_r, dsp_nxt, ssp_r, ssp_nxt, entry_r, entry_nxt;
	logic [23:0] dest_r, dest_nxt, maddr_r, maddr_nxt, xaddr_r, xaddr_nxt;
	logic [15:0] cnt_r, cnt_nxt, raddr_r, raddr_nxt, len_r, len_nxt;
	logic [15:0] dly_r, dly_nxt, mdat_r, mdat_nxt;
	logic [15:0] ioa_r, ioa_nxt, iod_r, iod_nxt, sine_r, sine_nxt;
	logic gim_r, gim_nxt, sxm_r, sxm_nxt, lcm_r, lcm_nxt;
	logic mwe_r, mwe_nxt, iowe_r, iowe_nxt, xs_r, xs_nxt;
	logic p16_r, p16_nxt, a24_r, a24_nxt, s16_r, s16_nxt, oe_r, oe_nxt;
	logic [15:0] f_data;
	logic f_valid, f_ready, take;

	bsq_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_data(src_data),
		.in_valid(src_valid),
		.in_ready(src_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);

	// Delay holds the FIFO, so the source sees back-pressure
	// Holding off one cycle lets a config write land first
	assign f_ready = !iowe_r && (state_r inside {ST_ENT_HI, ST_ENT_LO,
		ST_REG_CNT,
		ST_REG_ADDR, ST_REG_VAL, ST_SEC_LEN, ST_SEC_DH, ST_SEC_DL,
		ST_SEC_DATA});
	assign take = f_ready && f_valid;

	always_comb begin
		state_nxt = state_r;
		src_nxt = src_r;
		mode_nxt = mode_r;
		settle_nxt = settle_r;
		stk_nxt = stk_r;
		dsp_nxt = dsp_r;
		ssp_nxt = ssp_r;
		entry_nxt = entry_r;
		dest_nxt = dest_r;
		maddr_nxt = maddr_r;
		xaddr_nxt = xaddr_r;
		cnt_nxt = cnt_r;
		raddr_nxt = raddr_r;
		len_nxt = len_r;
		dly_nxt = dly_r;
		mdat_nxt = mdat_r;
		ioa_nxt = ioa_r;
		iod_nxt = iod_r;
		gim_nxt = gim_r;
		sxm_nxt = sxm_r;
		lcm_nxt = lcm_r;
		p16_nxt = p16_r;
		a24_nxt = a24_r;
		s16_nxt = s16_r;
		oe_nxt = oe_r;
		mwe_nxt = 1'b0;
		iowe_nxt = 1'b0;
		xs_nxt = 1'b0;
		sine_nxt = sine_rom[sine_addr];
		case (state_r)
			ST_INIT: begin
				dsp_nxt = DSP_INIT;
				ssp_nxt = SSP_INIT;
				stk_nxt = STK_32_SLOW;
				gim_nxt = 1'b1;
				sxm_nxt = 1'b0;
				lcm_nxt = 1'b1;
				settle_nxt = settle_r + 2'h1;
				// Lets the pin synchroniser fill before sampling
				if (settle_r == SETTLE_CYC) begin
					state_nxt = ST_SELECT;
				end
			end
			ST_SELECT: begin
				mode_nxt = pins_s_r;
				state_nxt = ST_ENT_HI;
				oe_nxt = 1'b1;
				case (pins_s_r)
					BM_SPI24: begin
						src_nxt = SRC_SPI;
						a24_nxt = 1'b1;
					end
					BM_SPI16: src_nxt = SRC_SPI;
					BM_USB: src_nxt = SRC_USB;
					BM_I2C: src_nxt = SRC_I2C;
					BM_PAR8: src_nxt = SRC_PAR;
					BM_PAR16: begin
						src_nxt = SRC_PAR;
						p16_nxt = 1'b1;
					end
					BM_SER8: src_nxt = SRC_SERIAL;
					BM_SER16: begin
						src_nxt = SRC_SERIAL;
						s16_nxt = 1'b1;
					end
					BM_HP_MUX, BM_HP_NMUX: begin
						src_nxt = SRC_HOST;
						oe_nxt = 1'b0;
						state_nxt = ST_HOST_WAIT;
					end
					BM_DIRECT: begin
						src_nxt = SRC_PAR;
						p16_nxt = 1'b1;
						oe_nxt = 1'b0;
						sxm_nxt = 1'b1;
						xaddr_nxt = DIRECT_ENTRY;
						xs_nxt = 1'b1;
						state_nxt = ST_RUN;
					end
					default: begin
						oe_nxt = 1'b0;
						state_nxt = ST_ERR;
					end
				endcase
			end
			ST_HOST_WAIT: begin
				if (done_s_r) begin
					sxm_nxt = 1'b1;
					xaddr_nxt = hent_s_r;
					xs_nxt = 1'b1;
					state_nxt = ST_RUN;
				end
			end
			ST_ENT_HI: begin
				if (take) begin
					entry_nxt[23:16] = f_data[7:0];
					mwe_nxt = 1'b1;
					maddr_nxt = ENTRY_HI_ADDR;
					mdat_nxt = f_data;
					state_nxt = ST_ENT_LO;
				end
			end
			ST_ENT_LO: begin
				if (take) begin
					entry_nxt[15:0] = f_data;
					mwe_nxt = 1'b1;
					maddr_nxt = ENTRY_LO_ADDR;
					mdat_nxt = f_data;
					state_nxt = ST_REG_CNT;
				end
			end
			ST_REG_CNT: begin
				if (take) begin
					cnt_nxt = f_data;
					state_nxt = (f_data == 16'h0000) ? ST_SEC_LEN : ST_REG_ADDR;
				end
			end
			ST_REG_ADDR: begin
				if (take) begin
					raddr_nxt = f_data;
					state_nxt = ST_REG_VAL;
				end
			end
			ST_REG_VAL: begin
				if (take) begin
					cnt_nxt = cnt_r - 16'h0001;
					if (raddr_r == DELAY_TAG) begin
						dly_nxt = f_data;
						state_nxt = ST_DELAY;
					end else begin
						iowe_nxt = 1'b1;
						ioa_nxt = raddr_r;
						iod_nxt = f_data;
						// Next word is taken only after the write lands
						state_nxt = (cnt_r == 16'h0001) ? ST_SEC_LEN
							: ST_REG_ADDR;
					end
				end
			end
			ST_DELAY: begin
				if (dly_r == 16'h0000) begin
					state_nxt = (cnt_r == 16'h0000) ? ST_SEC_LEN : ST_REG_ADDR;
				end else begin
					dly_nxt = dly_r - 16'h0001;
				end
			end
			ST_SEC_LEN: begin
				if (take) begin
					len_nxt = f_data;
					state_nxt = (f_data == 16'h0000) ? ST_FINISH : ST_SEC_DH;
				end
			end
			ST_SEC_DH: begin
				if (take) begin
					dest_nxt[23:16] = f_data[7:0];
					state_nxt = ST_SEC_DL;
				end
			end
			ST_SEC_DL: begin
				if (take) begin
					dest_nxt[15:0] = f_data;
					state_nxt = ST_SEC_DATA;
				end
			end
			ST_SEC_DATA: begin
				if (take) begin
					mwe_nxt = 1'b1;
					maddr_nxt = dest_r;
					mdat_nxt = f_data;
					dest_nxt = dest_r + 24'h000001;
					len_nxt = len_r - 16'h0001;
					if (len_r == 16'h0001) begin
						state_nxt = ST_SEC_LEN;
					end
				end
			end
			ST_FINISH: begin
				sxm_nxt = 1'b1;
				xaddr_nxt = entry_r;
				xs_nxt = 1'b1;
				state_nxt = ST_RUN;
			end
			ST_RUN, ST_ERR: state_nxt = state_r;
			default: state_nxt = ST_ERR;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pins_m_r <= 4'h0;
			pins_s_r <= 4'h0;
			done_m_r <= 1'b0;
			done_s_r <= 1'b0;
			hent_m_r <= 24'h000000;
			hent_s_r <= 24'h000000;
			state_r <= ST_INIT;
			{src_r, mode_r, settle_r, stk_r} <= {SRC_NONE, 4'h0, 2'h0, STK_32_SLOW};
			{dsp_r, ssp_r, entry_r, dest_r} <= '0;
			{maddr_r, xaddr_r, cnt_r, raddr_r, len_r} <= '0;
			{dly_r, mdat_r, ioa_r, iod_r, sine_r} <= '0;
			{gim_r, sxm_r, lcm_r, mwe_r, iowe_r, xs_r} <= 6'h38;
			{p16_r, a24_r, s16_r, oe_r} <= 4'h0;
		end else begin
			pins_m_r <= boot_select_pins;
			pins_s_r <= pins_m_r;
			done_m_r <= host_load_done;
			done_s_r <= done_m_r;
			hent_m_r <= host_entry;
			hent_s_r <= hent_m_r;
			state_r <= state_nxt;
			{src_r, mode_r, settle_r, stk_r} <= {src_nxt, mode_nxt, settle_nxt, stk_nxt};
			{dsp_r, ssp_r, entry_r, dest_r} <= {dsp_nxt, ssp_nxt, entry_nxt, dest_nxt};
			{maddr_r, xaddr_r, cnt_r, raddr_r, len_r} <=
				{maddr_nxt, xaddr_nxt, cnt_nxt, raddr_nxt, len_nxt};
			{dly_r, mdat_r, ioa_r, iod_r, sine_r} <=
				{dly_nxt, mdat_nxt, ioa_nxt, iod_nxt, sine_nxt};
			{gim_r, sxm_r, lcm_r, mwe_r, iowe_r, xs_r} <=
				{gim_nxt, sxm_nxt, lcm_nxt, mwe_nxt, iowe_nxt, xs_nxt};
			{p16_r, a24_r, s16_r, oe_r} <= {p16_nxt, a24_nxt, s16_nxt, oe_nxt};
		end
	end

	assign src_sel = src_r;
	assign {par_width16, spi_addr24, ser_width16} = {p16_r, a24_r, s16_r};
	assign data_stack_pointer = dsp_r;
	assign system_stack_pointer = ssp_r;
	assign stack_mode = stk_r;
	assign global_interrupt_mask = gim_r;
	assign sign_extension_mode = sxm_r;
	assign legacy_compatibility_mode = lcm_r;
	assign {mem_we, mem_addr, mem_wdata} = {mwe_r, maddr_r, mdat_r};
	assign {io_we, io_addr, io_wdata} = {iowe_r, ioa_r, iod_r};
	assign {exec_start, exec_addr} = {xs_r, xaddr_r};
	assign boot_done = state_r == ST_RUN;
	assign boot_error = state_r == ST_ERR;
	// Handshake rises during delays and once the jump is made
	assign handshake_o = state_r == ST_DELAY || state_r == ST_RUN;
	assign handshake_oe = oe_r;
	assign sine_data = sine_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_init_ptr;
		state_r == ST_SELECT |-> dsp_r == 24'h000090 && ssp_r == 24'h000080;
	endproperty
	a_init_ptr: assert property (p_init_ptr) else $error("bad stack init");
	property p_gim;
		state_r != ST_INIT |-> gim_r && lcm_r && stk_r == STK_32_SLOW;
	endproperty
	a_gim: assert property (p_gim) else $error("mask or mode lost");
	property p_sxm_copy;
		mwe_r && state_r inside {ST_SEC_LEN, ST_SEC_DATA} |-> !sxm_r;
	endproperty
	a_sxm_copy: assert property (p_sxm_copy) else $error("sxm set in copy");
	property p_jump;
		xs_r |-> sxm_r && lcm_r ##1 boot_done && !xs_r;
	endproperty
	a_jump: assert property (p_jump) else $error("bad jump state");
	property p_delay;
		state_r == ST_DELAY && dly_r != 16'h0000 |=>
			state_r == ST_DELAY && dly_r == $past(dly_r) - 16'h0001;
	endproperty
	a_delay: assert property (p_delay) else $error("delay count broken");
	property p_iowr;
		state_r == ST_REG_VAL && take && raddr_r != DELAY_TAG |=>
			io_we && io_addr == $past(raddr_r) && io_wdata == $past(f_data)
			&& !f_ready;
	endproperty
	a_iowr: assert property (p_iowr) else $error("config write wrong");
	property p_entry;
		state_r == ST_FINISH |=> exec_start && exec_addr == $past(entry_r);
	endproperty
	a_entry: assert property (p_entry) else $error("wrong entry");
	property p_host;
		state_r == ST_HOST_WAIT && !done_s_r |=> !exec_start;
	endproperty
	a_host: assert property (p_host) else $error("host jump early");
	property p_direct;
		state_r == ST_SELECT && pins_s_r == BM_DIRECT |=>
			exec_start && exec_addr == 24'h400000;
	endproperty
	a_direct: assert property (p_direct) else $error("direct exec wrong");
	property p_slot;
		state_r == ST_ENT_LO && take |=> mem_we && mem_addr == 24'h000061;
	endproperty
	a_slot: assert property (p_slot) else $error("entry slot wrong");
	property p_mode;
		!(state_r inside {ST_INIT, ST_SELECT}) |=> $stable(mode_r);
	endproperty
	a_mode: assert property (p_mode) else $error("mode resampled");
	c_table: cover property (state_r == ST_FINISH ##1 exec_start);
	c_delay: cover property (state_r == ST_DELAY ##1 state_r == ST_SEC_LEN);
	c_host: cover property (state_r == ST_HOST_WAIT ##1 exec_start);
endmodule

// File: bench/bsq_src_model.sv
// Boot-word source model: streams queued table words over valid/ready.
// Assumes words are pushed or flushed only while reset is held high.
module bsq_src_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic stall,
	input wire logic src_ready,
	output logic [15:0] src_data,
	output logic src_valid
);
	logic [15:0] q[$];
	logic take;
	task push(input logic [15:0] w);
		q.push_back(w);
	endtask
	task flush();
		q.delete();
	endtask
	assign take = src_valid && src_ready;
	// Word held until taken, table order kept
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			src_valid <= 1'b0;
			src_data <= 16'h0000;
		end else begin
			if (take)
				void'(q.pop_front());
			if (!src_valid || take) begin
				if (q.size() != 0 && !stall) begin
					src_valid <= 1'b1;
					src_data <= q[0];
				end else begin
					// Released data is scrambled, never left stale
					src_valid <= 1'b0;
					src_data <= ~src_data;
				end
			end
		end
	end
endmodule

// File: bench/testbench.sv
// Self-checking bench for the boot sequencer, with a reference in queues.
// Assumes a 10 MHz clock and boot words from the source model.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import bsq_pkg::*;
	logic mclk, rst, stall, host_load_done, src_valid, src_ready;
	logic [3:0] boot_select_pins;
	logic [23:0] host_entry, exp_exec;
	logic [15:0] src_data, lf, sl;
	bsq_src_t src_sel;
	logic par_width16, spi_addr24, ser_width16;
	logic [23:0] data_stack_pointer, system_stack_pointer;
	logic [1:0] stack_mode;
	logic global_interrupt_mask, sign_extension_mode;
	logic legacy_compatibility_mode, mem_we, io_we;
	logic [23:0] mem_addr, exec_addr;
	logic [15:0] mem_wdata, io_addr, io_wdata, sine_data;
	logic exec_start, boot_done, boot_error, handshake_o, handshake_oe;
	logic [7:0] sine_addr;
	logic full_seen;
	int errors, checks_done, hs;
	logic [15:0] tbl[$];
	logic [39:0] exp_mem[$], got_mem[$];
	logic [31:0] exp_io[$], got_io[$];
	logic [3:0] tm[7] = '{4'h1, 4'h9, 4'hA, 4'hE, 4'hF, 4'h2, 4'h3};
	logic [3:0] rm[5] = '{4'h0, 4'h4, 4'h7, 4'hC, 4'hD};

	bsq_top u_dut (.mclk, .rst, .boot_select_pins, .host_load_done,
		.host_entry, .src_data, .src_valid, .src_ready, .src_sel,
		.par_width16, .spi_addr24, .ser_width16, .data_stack_pointer,
		.system_stack_pointer, .stack_mode, .global_interrupt_mask,
		.sign_extension_mode, .legacy_compatibility_mode, .mem_we,
		.mem_addr, .mem_wdata, .io_we, .io_addr, .io_wdata, .exec_start,
		.exec_addr, .boot_done, .boot_error, .handshake_o, .handshake_oe,
		.sine_addr, .sine_data);
	bsq_src_model u_src (.mclk, .rst, .stall, .src_ready, .src_data,
		.src_valid);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task rnd(output logic [15:0] v);
		lf = nxt(lf);
		v = lf;
	endtask
	task chk(input string n, input logic [39:0] e, input logic [39:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task print_verdict();
		$display("errors %0d checks_done %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	function automatic logic [5:0] exp_cfg(input logic [3:0] m);
		case (m)
			BM_SPI24: return {SRC_SPI, 3'b010};
			BM_SPI16: return {SRC_SPI, 3'b000};
			BM_PAR8: return {SRC_PAR, 3'b000};
			BM_PAR16: return {SRC_PAR, 3'b100};
			BM_SER16: return {SRC_SERIAL, 3'b001};
			BM_SER8: return {SRC_SERIAL, 3'b000};
			BM_USB: return {SRC_USB, 3'b000};
			BM_I2C: return {SRC_I2C, 3'b000};
			default: return {SRC_HOST, 3'b000};
		endcase
	endfunction

	// Stall pattern on its own register so the two streams never race
	always @(posedge mclk) begin
		sl <= nxt(sl);
		stall <= sl[0] & sl[2];
	end
	// Registered outputs move on the rising edge; watch them mid-cycle
	always @(negedge mclk) begin
		if (!rst && mem_we)
			got_mem.push_back({mem_addr, mem_wdata});
		if (!rst && mem_we && mem_addr > ENTRY_LO_ADDR)
			chk("sxm_copy", 0, sign_extension_mode);
		if (!rst && io_we)
			got_io.push_back({io_addr, io_wdata});
		if (!rst && !src_ready)
			full_seen = 1'b1;
		if (!rst && handshake_o && !exec_start && !boot_done)
			hs++;
	end

	task do_reset(input logic [3:0] m);
		@(posedge mclk);
		rst <= 1'b1;
		host_load_done <= 1'b0;
		boot_select_pins <= m;
		@(negedge mclk);
		chk("gim_rst", 1, global_interrupt_mask);
		u_src.flush();
		got_mem.delete();
		got_io.delete();
		hs = 0;
		full_seen = 1'b0;
		foreach (tbl[i])
			u_src.push(tbl[i]);
	endtask
	task release_rst(input logic [3:0] m);
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(negedge mclk);
		chk("dsp", DSP_INIT, data_stack_pointer);
		chk("ssp", SSP_INIT, system_stack_pointer);
		chk("stk", STK_32_SLOW, stack_mode);
		chk("sxm_init", 0, sign_extension_mode);
		chk("cm_init", 1, legacy_compatibility_mode);
	endtask
	task wait_exec(input logic [23:0] ea);
		int i;
		for (i = 0; i < 3000 && exec_start !== 1'b1; i++)
			@(negedge mclk);
		chk("exec_seen", 1, i < 3000);
		chk("exec_addr", ea, exec_addr);
		chk("gim_exec", 1, global_interrupt_mask);
		chk("cm_exec", 1, legacy_compatibility_mode);
		@(negedge mclk);
		chk("done", 1, boot_done);
		chk("sxm_exec", 1, sign_extension_mode);
	endtask

	task boot(input logic [3:0] m, input logic [15:0] dly, input int n,
		input int abort);
		logic [15:0] hi, lo, a, v;
		logic [23:0] d;
		tbl.delete();
		exp_mem.delete();
		rnd(hi);
		hi = hi & 16'h00FF;
		rnd(lo);
		rnd(a);
		rnd(v);
		a = a & 16'h7FFF;
		exp_exec = {hi[7:0], lo};
		exp_mem.push_back({ENTRY_HI_ADDR, hi});
		exp_mem.push_back({ENTRY_LO_ADDR, lo});
		exp_io = '{{a, v}};
		d = {8'h00, (lf & 16'h0FFF) | 16'h0100};
		tbl = '{hi, lo, 16'h0002, a, v, DELAY_TAG, dly, 16'(n), 16'h0000,
			d[15:0]};
		for (int i = 0; i < n; i++) begin
			rnd(v);
			tbl.push_back(v);
			exp_mem.push_back({d + 24'(i), v});
		end
		tbl.push_back(16'h0000);
		do_reset(m);
		if (abort != 0) begin
			release_rst(m);
			repeat (14) @(negedge mclk);
			do_reset(m);
		end
		release_rst(m);
		wait_exec(exp_exec);
		chk("cfg", exp_cfg(m), {src_sel, par_width16, spi_addr24,
			ser_width16});
		chk("hs_oe", 1, handshake_oe);
		chk("mem_n", exp_mem.size(), got_mem.size());
		foreach (exp_mem[i])
			chk("mem", exp_mem[i], got_mem[i]);
		chk("io_n", 1, got_io.size());
		chk("io", exp_io[0], got_io[0]);
		chk("delay", 1, hs >= dly && hs <= dly + 2);
	endtask

	initial begin
		rst = 1'b1;
		stall = 1'b0;
		host_load_done = 1'b0;
		host_entry = 24'h000000;
		boot_select_pins = 4'h0;
		sine_addr = 8'h00;
		lf = 16'd48;
		sl = 16'd48;
		errors = 0;
		checks_done = 0;
		boot(BM_PAR16, 16'd40, 20, 0);
		chk("fifo_full", 1, full_seen);
		foreach (tm[i])
			boot(tm[i], 16'd3, 4, 0);
		boot(BM_PAR8, 16'd0, 1, 1);
		tbl.delete();
		for (int k = 0; k < 2; k++) begin
			do_reset(k == 0 ? BM_HP_MUX : BM_HP_NMUX);
			release_rst(BM_HP_MUX);
			for (int i = 0; i < 30; i++) begin
				@(negedge mclk);
				chk("early", 0, exec_start | boot_done);
			end
			rnd(lf);
			@(posedge mclk);
			host_entry <= {8'h3C, lf};
			@(posedge mclk);
			host_load_done <= 1'b1;
			@(negedge mclk);
			wait_exec({8'h3C, lf});
			chk("host_sel", SRC_HOST, src_sel);
		end
		do_reset(BM_DIRECT);
		release_rst(BM_DIRECT);
		wait_exec(DIRECT_ENTRY);
		chk("direct_mem", 0, got_mem.size());
		foreach (rm[i]) begin
			do_reset(rm[i]);
			release_rst(rm[i]);
			repeat (10) @(negedge mclk);
			chk("resv_err", 1, boot_error);
			chk("resv_run", 0, boot_done);
		end
		for (int i = 0; i < 256; i += 5) begin
			int e, g;
			@(posedge mclk);
			sine_addr <= 8'(i);
			@(posedge mclk);
			@(negedge mclk);
			e = $rtoi($floor(32767.0 * $sin(6.2831853 * i / 256) + 0.5));
			g = $signed(sine_data);
			chk("sine", 1, g - e <= 6 && e - g <= 6);
		end
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		print_verdict();
	end
endmodule
